// >>> core/pll_lock_detect.v
// lock detect, lock pin drive, monitor muxes, output gating, counter reset and divider delays
`timescale 1ns/1ns
`include "lock_detect_defs.vh"
module pll_lock_detect (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // register access
    input wire [9:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_we_i,
    output wire [7:0] reg_rdata_o,
    // phase detector
    input wire pfd_cycle_i,
    input wire [7:0] edge_diff_i,
    input wire ald_pulse_i,
    // sync pin
    input wire sync_n_i,
    // counter control
    output wire counter_reset_o,
    // divider delay cells
    output wire ref_delay_en_o,
    output wire [2:0] ref_delay_code_o,
    output wire [9:0] ref_delay_ps_o,
    output wire fb_delay_en_o,
    output wire [2:0] fb_delay_code_o,
    output wire [9:0] fb_delay_ps_o,
    // lock indicator pin
    output wire lock_pin_o,
    output wire lock_pin_oe_o,
    output wire lock_pin_source_o,
    // monitor pins
    output wire status_pin_o,
    output wire reference_monitor_pin_o,
    // holdover and output gating
    output wire holdover_lock_sense_o,
    output wire [15:0] clk_out_enable_o,
    output wire digital_lock_flag_o
);
    reg [7:0] status_abp_q;
    reg [7:0] lock_cfg_q;
    reg [7:0] sync_delay_q;
    reg [7:0] lock_pin_sel_q;
    reg [7:0] reference_monitor_pin_sel_q;
    reg [7:0] cmp_ctrl_q;
    reg [7:0] aux_ctrl_q;
    reg [7:0] output_gate_on_lock_low_q;
    reg [7:0] output_gate_on_lock_high_q;
    reg [7:0] rdata_q;
    reg [7:0] rdata_d;
    reg ald_q;

    wire digital_lock_flag;
    wire current_qualified_lock;
    wire cmp_en;
    wire cs_mode;
    wire [5:0] ld_sel;
    wire [7:0] lock_thr;
    wire [7:0] unlock_thr;
    wire [7:0] count_target;
    wire win_narrow;
    wire [1:0] abp_code;
    wire [1:0] count_code;
    wire ald_n_mode;
    wire ald_p_mode;
    wire sync_reset_en;
    wire sync_reset_req;
    wire [5:0] status_sel;
    wire [5:0] reference_monitor_pin_sel;

    // delay of a cell in picoseconds for a code
    function [9:0] delay_ps;
        input [2:0] code;
        reg [31:0] prod;
        begin
            prod = code * `DELAY_STEP_PS;
            // largest code stays below 1000 ps, so the cut drops only zeros
            delay_ps = prod[9:0];
        end
    endfunction

    // monitor pin selector shared by status and reference monitor pins
    function mon_mux;
        input [5:0] sel;
        input dld;
        input cmp;
        input cmp_enable;
        begin
            if (sel == `MON_SEL_DLD) begin
                mon_mux = dld;
            end else if (sel == `MON_SEL_CMP_HIGH) begin
                mon_mux = cmp_enable & cmp;
            end else if (sel == `MON_SEL_CMP_LOW) begin
                mon_mux = cmp_enable & ~cmp;
            end else begin
                mon_mux = 1'b0;
            end
        end
    endfunction

    // window figure for a range bit and antibacklash code
    function [7:0] window_thr;
        input narrow;
        input [1:0] abp;
        input unlock;
        reg [7:0] base;
        begin
            if (narrow) begin
                base = unlock ? `UNLOCK_THR_LOW : `LOCK_THR_LOW;
            end else begin
                base = unlock ? `UNLOCK_THR_HIGH : `LOCK_THR_HIGH;
            end
            window_thr = base + {6'h00, abp} * `ABP_STEP;
        end
    endfunction

    // consecutive in-window cycles for a count code
    function [7:0] count_of;
        input [1:0] code;
        begin
            if (code == 2'b00) begin
                count_of = `LD_COUNT_0;
            end else if (code == 2'b01) begin
                count_of = `LD_COUNT_1;
            end else if (code == 2'b10) begin
                count_of = `LD_COUNT_2;
            end else begin
                count_of = `LD_COUNT_3;
            end
        end
    endfunction

    // register writes
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            status_abp_q <= `REG_RESET;
            lock_cfg_q <= `REG_RESET;
            sync_delay_q <= `REG_RESET;
            lock_pin_sel_q <= `REG_RESET;
            reference_monitor_pin_sel_q <= `REG_RESET;
            cmp_ctrl_q <= `REG_RESET;
            aux_ctrl_q <= `REG_RESET;
            output_gate_on_lock_low_q <= `REG_RESET;
            output_gate_on_lock_high_q <= `REG_RESET;
            // the lock state register is read-only; unmapped writes are dropped
        end else if (reg_we_i) begin
            if (reg_addr_i == `OFS_STATUS_ABP) begin
                status_abp_q <= reg_wdata_i;
            end else if (reg_addr_i == `OFS_LOCK_CFG) begin
                lock_cfg_q <= reg_wdata_i;
            end else if (reg_addr_i == `OFS_SYNC_DELAY) begin
                sync_delay_q <= reg_wdata_i;
            end else if (reg_addr_i == `OFS_LOCK_PIN_SEL) begin
                // upper bits are reserved and read back as zero
                lock_pin_sel_q <= {2'b00, reg_wdata_i[`LD_SEL_MSB:`LD_SEL_LSB]};
            end else if (reg_addr_i == `OFS_REFERENCE_MONITOR_PIN_SEL) begin
                reference_monitor_pin_sel_q <= {3'b000, reg_wdata_i[`REFERENCE_MONITOR_PIN_SEL_MSB:`REFERENCE_MONITOR_PIN_SEL_LSB]};
            end else if (reg_addr_i == `OFS_CMP_CTRL) begin
                cmp_ctrl_q <= reg_wdata_i;
            end else if (reg_addr_i == `OFS_AUX_CTRL) begin
                aux_ctrl_q <= {5'b00000, reg_wdata_i[2:0]};
            end else if (reg_addr_i == `OFS_GATE_LOW) begin
                output_gate_on_lock_low_q <= reg_wdata_i;
            end else if (reg_addr_i == `OFS_GATE_HIGH) begin
                output_gate_on_lock_high_q <= reg_wdata_i;
            end
        end
    end

    // read data registered one cycle after the address; unmapped reads zero
    always @* begin
        rdata_d = 8'h00;
        if (reg_addr_i == `OFS_STATUS_ABP) begin
            rdata_d = status_abp_q;
        end else if (reg_addr_i == `OFS_LOCK_CFG) begin
            rdata_d = lock_cfg_q;
        end else if (reg_addr_i == `OFS_SYNC_DELAY) begin
            rdata_d = sync_delay_q;
        end else if (reg_addr_i == `OFS_LOCK_PIN_SEL) begin
            rdata_d = lock_pin_sel_q;
        end else if (reg_addr_i == `OFS_REFERENCE_MONITOR_PIN_SEL) begin
            rdata_d = reference_monitor_pin_sel_q;
        end else if (reg_addr_i == `OFS_CMP_CTRL) begin
            rdata_d = cmp_ctrl_q;
        end else if (reg_addr_i == `OFS_AUX_CTRL) begin
            rdata_d = aux_ctrl_q;
        end else if (reg_addr_i == `OFS_LOCK_STATE) begin
            rdata_d = {5'b00000, current_qualified_lock, cs_mode, digital_lock_flag};
        end else if (reg_addr_i == `OFS_GATE_LOW) begin
            rdata_d = output_gate_on_lock_low_q;
        end else if (reg_addr_i == `OFS_GATE_HIGH) begin
            rdata_d = output_gate_on_lock_high_q;
        end
    end

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // pump activity registered so the open-drain enable cannot glitch
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ald_q <= 1'b0;
        end else begin
            ald_q <= ald_pulse_i;
        end
    end

    assign reg_rdata_o = rdata_q;

    // window figures from range bit and antibacklash field; unlock always the wider
    assign win_narrow = lock_cfg_q[`WIN_RANGE_BIT];
    assign abp_code = status_abp_q[`ABP_MSB:`ABP_LSB];
    assign count_code = lock_cfg_q[`LD_COUNT_MSB:`LD_COUNT_LSB];
    assign lock_thr = window_thr(win_narrow, abp_code, 1'b0);
    assign unlock_thr = window_thr(win_narrow, abp_code, 1'b1);
    assign count_target = count_of(count_code);

    dld_counter u_dld (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pfd_cycle_i(pfd_cycle_i),
        .edge_diff_i(edge_diff_i),
        .disable_i(lock_cfg_q[`LD_DISABLE_BIT]),
        .lock_thr_i(lock_thr),
        .unlock_thr_i(unlock_thr),
        .count_target_i(count_target),
        .dld_o(digital_lock_flag)
    );

    assign ld_sel = lock_pin_sel_q[`LD_SEL_MSB:`LD_SEL_LSB];
    assign ald_n_mode = (ld_sel == `LD_SEL_ALD_NCH);
    assign ald_p_mode = (ld_sel == `LD_SEL_ALD_PCH);
    // both the zero code and the dedicated code select the current-source drive
    assign cs_mode = (ld_sel == `LD_SEL_DLD) || (ld_sel == `LD_SEL_CURRENT_QUALIFIED_LOCK);
    assign cmp_en = cmp_ctrl_q[`CMP_EN_BIT];

    cs_qualifier u_cs (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .active_i(cs_mode),
        .dld_i(digital_lock_flag),
        .cmp_o(current_qualified_lock)
    );

    // lock pin: current source while locked, hard low otherwise; open-drain pulses in analog modes
    assign lock_pin_source_o = cs_mode & digital_lock_flag;
    // n-channel pulls low, p-channel pulls high; the resistor sets the idle level
    assign lock_pin_o = cs_mode ? digital_lock_flag : ald_p_mode;
    assign lock_pin_oe_o = cs_mode ? 1'b1 : (ald_n_mode | ald_p_mode) & ald_q;

    assign status_sel = status_abp_q[`STATUS_SEL_MSB:`STATUS_SEL_LSB];
    assign reference_monitor_pin_sel = {1'b0, reference_monitor_pin_sel_q[`REFERENCE_MONITOR_PIN_SEL_MSB:`REFERENCE_MONITOR_PIN_SEL_LSB]};
    // comparator codes read low while the comparator is off
    assign status_pin_o = mon_mux(status_sel,
        digital_lock_flag, current_qualified_lock, cmp_en);
    assign reference_monitor_pin_o = mon_mux(reference_monitor_pin_sel,
        digital_lock_flag, current_qualified_lock, cmp_en);

    // holdover sees a permanent high when the comparator is off
    assign holdover_lock_sense_o = cmp_en ? current_qualified_lock : 1'b1;

    // gating acts without the clock; ungated outputs stay enabled
    assign clk_out_enable_o = ~{output_gate_on_lock_high_q, output_gate_on_lock_low_q}
        | {16{current_qualified_lock}};

    // level sensitive: counters stay held for as long as the pin is low
    assign sync_reset_en = (sync_delay_q[`SYNC_RST_MSB:`SYNC_RST_LSB] != 2'b00);
    assign sync_reset_req = sync_reset_en & ~sync_n_i;
    assign counter_reset_o = aux_ctrl_q[`CNT_SWRST_BIT] | sync_reset_req;

    assign ref_delay_en_o = aux_ctrl_q[`REF_DLY_EN_BIT];
    assign ref_delay_code_o = sync_delay_q[`REF_DLY_MSB:`REF_DLY_LSB];
    assign ref_delay_ps_o = ref_delay_en_o ? delay_ps(ref_delay_code_o) : 10'h000;
    assign fb_delay_en_o = aux_ctrl_q[`FB_DLY_EN_BIT];
    assign fb_delay_code_o = sync_delay_q[`FB_DLY_MSB:`FB_DLY_LSB];
    assign fb_delay_ps_o = fb_delay_en_o ? delay_ps(fb_delay_code_o) : 10'h000;

    assign digital_lock_flag_o = digital_lock_flag;
endmodule

// >>> include/lock_detect_defs.vh
// register offsets, field positions, reset values and timing constants of the lock-detect block
`ifndef LOCK_DETECT_DEFS_VH
`define LOCK_DETECT_DEFS_VH

// register offsets
`define OFS_STATUS_ABP 10'h017
`define OFS_LOCK_CFG 10'h018
`define OFS_SYNC_DELAY 10'h019
`define OFS_LOCK_PIN_SEL 10'h01a
`define OFS_REFERENCE_MONITOR_PIN_SEL 10'h01b
`define OFS_CMP_CTRL 10'h01d
`define OFS_AUX_CTRL 10'h01e
`define OFS_LOCK_STATE 10'h01f
`define OFS_GATE_LOW 10'h0fc
`define OFS_GATE_HIGH 10'h0fd

// reset value of every control register
`define REG_RESET 8'h00

// field positions
`define ABP_LSB 0
`define ABP_MSB 1
`define STATUS_SEL_LSB 2
`define STATUS_SEL_MSB 7
`define LD_DISABLE_BIT 3
`define WIN_RANGE_BIT 4
`define LD_COUNT_LSB 5
`define LD_COUNT_MSB 6
`define SYNC_RST_LSB 6
`define SYNC_RST_MSB 7
`define REF_DLY_LSB 3
`define REF_DLY_MSB 5
`define FB_DLY_LSB 0
`define FB_DLY_MSB 2
`define LD_SEL_LSB 0
`define LD_SEL_MSB 5
`define REFERENCE_MONITOR_PIN_SEL_LSB 0
`define REFERENCE_MONITOR_PIN_SEL_MSB 4
`define CMP_EN_BIT 3
`define CNT_SWRST_BIT 0
`define REF_DLY_EN_BIT 1
`define FB_DLY_EN_BIT 2

// lock pin selector codes
`define LD_SEL_DLD 6'h00
`define LD_SEL_ALD_NCH 6'h01
`define LD_SEL_ALD_PCH 6'h02
`define LD_SEL_CURRENT_QUALIFIED_LOCK 6'h04

// status and reference monitor selector codes
`define MON_SEL_LOW 6'h00
`define MON_SEL_DLD 6'h01
`define MON_SEL_CMP_HIGH 6'h02
`define MON_SEL_CMP_LOW 6'h03

// consecutive in-window cycles per count code
`define LD_COUNT_0 8'h05
`define LD_COUNT_1 8'h10
`define LD_COUNT_2 8'h40
`define LD_COUNT_3 8'hff

// windows in units of 100 ps of edge difference
`define LOCK_THR_HIGH 8'h23
`define UNLOCK_THR_HIGH 8'h46
`define LOCK_THR_LOW 8'h0a
`define UNLOCK_THR_LOW 8'h14
`define ABP_STEP 8'h05

// current-source qualifier: source current in microamps, charge trip in clock cycles
`define CS_CURRENT_UA 110
`define CS_TRIP_CYCLES 16'h0400

// delay cells: total range in picoseconds over the three-bit code
`define DELAY_RANGE_PS 1000
`define DELAY_CODE_MAX 7
`define DELAY_STEP_PS (`DELAY_RANGE_PS / `DELAY_CODE_MAX)

`endif

// >>> core/dld_counter.v
// digital lock flag: consecutive in-window count with wider unlock window
`timescale 1ns/1ns
`include "lock_detect_defs.vh"
module dld_counter (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // phase detector measurement
    input wire pfd_cycle_i,
    input wire [7:0] edge_diff_i,
    // configuration
    input wire disable_i,
    input wire [7:0] lock_thr_i,
    input wire [7:0] unlock_thr_i,
    input wire [7:0] count_target_i,
    // result
    output wire dld_o
);
    localparam ST_UNLOCKED = 1'b0;
    localparam ST_LOCKED = 1'b1;

    reg state_q;
    reg state_d;
    reg [7:0] cnt_q;
    reg [7:0] cnt_d;

    always @* begin
        state_d = state_q;
        cnt_d = cnt_q;
        if (disable_i) begin
            state_d = ST_UNLOCKED;
            cnt_d = 8'h00;
        end else if (pfd_cycle_i) begin
            case (state_q)
                ST_UNLOCKED: begin
                    if (edge_diff_i < lock_thr_i) begin
                        if (cnt_q + 8'h01 >= count_target_i) begin
                            state_d = ST_LOCKED;
                            cnt_d = 8'h00;
                        end else begin
                            cnt_d = cnt_q + 8'h01;
                        end
                    end else begin
                        cnt_d = 8'h00;
                    end
                end
                ST_LOCKED: begin
                    // one cycle beyond the unlock window is enough to drop lock
                    if (edge_diff_i > unlock_thr_i) begin
                        state_d = ST_UNLOCKED;
                    end
                end
                default: state_d = ST_UNLOCKED;
            endcase
        end
    end

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= ST_UNLOCKED;
            cnt_q <= 8'h00;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    assign dld_o = (state_q == ST_LOCKED);
endmodule

// >>> core/cs_qualifier.v
// current-source lock qualifier: capacitor charge model and pin comparator
`timescale 1ns/1ns
`include "lock_detect_defs.vh"
module cs_qualifier (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // control
    input wire active_i,
    input wire dld_i,
    // result
    output wire cmp_o
);
    reg [15:0] charge_q;

    // any false cycle discharges at once, so the ramp always restarts from zero
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            charge_q <= 16'h0000;
        end else if (!active_i || !dld_i) begin
            charge_q <= 16'h0000;
        end else if (charge_q != `CS_TRIP_CYCLES) begin
            charge_q <= charge_q + 16'h0001;
        end
    end

    // the pin is shorted the moment the flag drops, so the comparator falls with it
    assign cmp_o = active_i & dld_i & (charge_q == `CS_TRIP_CYCLES);
endmodule

// >>> tb/pll_lock_detect_chk.sv
// port checker for the lock-detect block
`timescale 1ns/1ns
module pll_lock_detect_chk (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // inputs
    input wire logic [9:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic pfd_cycle_i,
    input wire logic [7:0] edge_diff_i,
    input wire logic sync_n_i,
    // outputs
    input wire logic counter_reset_o,
    input wire logic ref_delay_en_o,
    input wire logic [2:0] ref_delay_code_o,
    input wire logic [9:0] ref_delay_ps_o,
    input wire logic lock_pin_o,
    input wire logic lock_pin_oe_o,
    input wire logic lock_pin_source_o,
    input wire logic holdover_lock_sense_o,
    input wire logic [15:0] clk_out_enable_o,
    input wire logic digital_lock_flag_o
);
    logic sync_en_q, swrst_q, cmp_en_q, out_q, wr_q, wr_qq;
    // disable write may clear the flag one edge late, so keep two stages
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            {sync_en_q, swrst_q, cmp_en_q, out_q, wr_q, wr_qq} <= 6'h00;
        end else begin
            out_q <= pfd_cycle_i && edge_diff_i > 8'h14;
            wr_q <= reg_we_i && reg_addr_i == 10'h018;
            wr_qq <= wr_q;
            if (reg_we_i && reg_addr_i == 10'h019)
                sync_en_q <= |reg_wdata_i[7:6];
            if (reg_we_i && reg_addr_i == 10'h01e)
                swrst_q <= reg_wdata_i[0];
            if (reg_we_i && reg_addr_i == 10'h01d)
                cmp_en_q <= reg_wdata_i[3];
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_locked_quiet;
        digital_lock_flag_o && !pfd_cycle_i && !reg_we_i;
    endsequence
    sequence s_unlocked_quiet;
        !digital_lock_flag_o && !pfd_cycle_i;
    endsequence
    a_flag_holds: assert property (s_locked_quiet |=> digital_lock_flag_o)
        else $error("lock flag fell with no cause");
    a_lock_needs_pulse: assert property (s_unlocked_quiet |=> !digital_lock_flag_o)
        else $error("lock flag rose with no compare pulse");
    a_lock_in_window: assert property ($rose(digital_lock_flag_o) |-> $past(edge_diff_i) < 8'h32)
        else $error("lock flag rose on an out-of-window cycle");
    a_unlock_cause: assert property ($fell(digital_lock_flag_o) |-> out_q || wr_q || wr_qq)
        else $error("lock flag fell inside the unlock window");
    a_source_on_lock: assert property (lock_pin_source_o |-> digital_lock_flag_o && lock_pin_oe_o && lock_pin_o)
        else $error("lock pin source on without lock");
    a_counter_reset: assert property (counter_reset_o == (swrst_q || (sync_en_q && !sync_n_i)))
        else $error("counter reset mismatch");
    a_delay_scale: assert property (ref_delay_ps_o == (ref_delay_en_o ? 10'd142 * {7'h00, ref_delay_code_o} : 10'h000))
        else $error("reference delay value mismatch");
    a_gate_open: assert property (cmp_en_q && holdover_lock_sense_o |-> clk_out_enable_o == 16'hffff)
        else $error("gated output closed while qualified");
    a_cmp_forced: assert property (!cmp_en_q |-> holdover_lock_sense_o)
        else $error("holdover sense low with comparator off");
    a_cmp_needs_lock: assert property (cmp_en_q && holdover_lock_sense_o |-> digital_lock_flag_o)
        else $error("comparator high without lock");
endmodule
bind pll_lock_detect pll_lock_detect_chk u_chk (.clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_we_i,
    .pfd_cycle_i, .edge_diff_i, .sync_n_i, .counter_reset_o, .ref_delay_en_o, .ref_delay_code_o,
    .ref_delay_ps_o, .lock_pin_o, .lock_pin_oe_o, .lock_pin_source_o, .holdover_lock_sense_o,
    .clk_out_enable_o, .digital_lock_flag_o);

// >>> tb/pfd_source_model.sv
// phase detector model: spaced compare pulses carrying an edge difference
`timescale 1ns/1ns
module pfd_source_model #(
    parameter int GAP = 3
) (
    input wire logic clk_i,
    input wire logic run_i,
    input wire logic [7:0] diff_i,
    output logic pfd_cycle_o,
    output logic [7:0] edge_diff_o,
    output logic ald_pulse_o
);
    int cnt = 0;
    initial begin
        pfd_cycle_o = 1'b0;
        edge_diff_o = 8'h00;
        ald_pulse_o = 1'b0;
    end
    // gap of several clocks keeps the compare period above the widest unlock window
    always @(negedge clk_i) begin
        cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
        pfd_cycle_o <= run_i && cnt == 0;
        // difference is not valid between pulses, so it keeps changing
        edge_diff_o <= (run_i && cnt == 0) ? diff_i : ~edge_diff_o;
        ald_pulse_o <= run_i && cnt == 0 && diff_i != 8'h00;
    end
endmodule

// >>> tb/pll_lock_detect_tb_top.sv
// testbench for the lock-detect block
`timescale 1ns/1ns
module pll_lock_detect_tb_top;
    logic clk_i = 0, rst_i = 1, reg_we_i = 0, sync_n_i = 1, run = 0, exp_lock = 0, track = 0, ald_on = 0;
    logic [1:0] ald_seen = 2'b00;
    logic [9:0] reg_addr_i = 10'h000;
    logic [7:0] reg_wdata_i = 8'h00, diff = 8'h00, lthr, uthr, tgt, cnt;
    wire [7:0] reg_rdata_o, edge_diff_i;
    wire pfd_cycle_i, ald_pulse_i, counter_reset_o, ref_delay_en_o, fb_delay_en_o, lock_pin_o, lock_pin_oe_o;
    wire lock_pin_source_o, status_pin_o, reference_monitor_pin_o, holdover_lock_sense_o, digital_lock_flag_o;
    wire [2:0] ref_delay_code_o, fb_delay_code_o;
    wire [9:0] ref_delay_ps_o, fb_delay_ps_o;
    wire [15:0] clk_out_enable_o;
    integer seed = 41491, mismatches = 0, compares = 0, cycles = 0, k, r;
    pll_lock_detect u_dut (.clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_rdata_o, .pfd_cycle_i,
        .edge_diff_i, .ald_pulse_i, .sync_n_i, .counter_reset_o, .ref_delay_en_o, .ref_delay_code_o,
        .ref_delay_ps_o, .fb_delay_en_o, .fb_delay_code_o, .fb_delay_ps_o, .lock_pin_o, .lock_pin_oe_o,
        .lock_pin_source_o, .status_pin_o, .reference_monitor_pin_o, .holdover_lock_sense_o,
        .clk_out_enable_o, .digital_lock_flag_o);
    pfd_source_model u_pfd (.clk_i, .run_i(run), .diff_i(diff), .pfd_cycle_o(pfd_cycle_i),
        .edge_diff_o(edge_diff_i), .ald_pulse_o(ald_pulse_i));
    initial forever #5 clk_i = ~clk_i;
    task automatic test_done;
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            mismatches = mismatches + 1;
            test_done;
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        compares = compares + 1;
        if (seen !== want) begin
            mismatches = mismatches + 1;
            $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(negedge clk_i);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_we_i = 1;
        @(negedge clk_i);
        reg_we_i = 0;
    endtask
    task automatic rd(input logic [9:0] a, input logic [7:0] want);
        @(negedge clk_i);
        reg_addr_i = a;
        @(negedge clk_i);
        check(32'(reg_rdata_o), 32'(want));
    endtask
    function automatic logic [7:0] thr(input logic rng, input logic [1:0] abp, input logic unl);
        thr = (rng ? (unl ? 8'h14 : 8'h0a) : (unl ? 8'h46 : 8'h23)) + 8'h05 * {6'h00, abp};
    endfunction
    function automatic logic [7:0] tgt_of(input logic [1:0] c);
        tgt_of = c == 2'd0 ? 8'h05 : c == 2'd1 ? 8'h10 : c == 2'd2 ? 8'h40 : 8'hff;
    endfunction
    // reference lock flag, updated on the edge that takes each compare pulse
    always @(posedge clk_i) begin
        if (pfd_cycle_i && !exp_lock) begin
            cnt = edge_diff_i < lthr ? cnt + 8'h01 : 8'h00;
            exp_lock = cnt == tgt;
        end else if (pfd_cycle_i && edge_diff_i > uthr) begin
            exp_lock = 0;
            cnt = 8'h00;
        end
    end
    always @(negedge clk_i)
        if (track) check(32'(digital_lock_flag_o), 32'(exp_lock));
    // open-drain pulses seen on the lock pin: bit 0 low-going, bit 1 high-going
    always @(negedge clk_i)
        if (ald_on && lock_pin_oe_o) ald_seen <= ald_seen | {lock_pin_o, !lock_pin_o};
    task automatic cfg(input logic rng, input logic [1:0] abp, input logic [1:0] code);
        track = 0;
        wr(10'h018, 8'h08);
        wr(10'h017, {6'h00, abp});
        wr(10'h018, {1'b0, code, rng, 4'h0});
        lthr = thr(rng, abp, 0);
        uthr = thr(rng, abp, 1);
        tgt = tgt_of(code);
        exp_lock = 0;
        cnt = 8'h00;
        track = 1;
    endtask
    task automatic pulses(input int n, input logic rnd, input logic [7:0] d);
        repeat (n * 3) begin
            @(negedge clk_i);
            r = $random(seed);
            run <= 1'b1;
            diff <= !rnd ? d : r[1:0] == 2'b00 ? r[15:8] : {3'h0, r[12:8]};
        end
        run <= 1'b0;
        repeat (4) @(negedge clk_i);
    endtask
    initial begin
        repeat (12) @(negedge clk_i);
        check(32'({holdover_lock_sense_o, counter_reset_o, clk_out_enable_o}), 32'h2ffff);
        rst_i = 0;
        sync_n_i = 0;
        rd(10'h019, 8'h00);
        check(32'(counter_reset_o), 32'h0);
        rd(10'h0fc, 8'h00);
        rd(10'h3ff, 8'h00);
        wr(10'h0fd, 8'h3c);
        wr(10'h01f, 8'hff);
        rd(10'h0fd, 8'h3c);
        rd(10'h01f, 8'h02);
        wr(10'h019, 8'h6a);
        check(32'(counter_reset_o), 32'h1);
        sync_n_i = 1;
        wr(10'h01e, 8'h07);
        check(32'(counter_reset_o), 32'h1);
        check(32'({ref_delay_en_o, fb_delay_en_o, ref_delay_code_o, fb_delay_code_o,
            ref_delay_ps_o, fb_delay_ps_o}), 32'({2'b11, 3'd5, 3'd2, 10'd710, 10'd284}));
        wr(10'h01e, 8'h00);
        check(32'({counter_reset_o, ref_delay_ps_o, fb_delay_ps_o}), 32'h0);
        for (k = 0; k < 4; k++) begin
            cfg(k[0], k[1:0], k[1:0]);
            pulses(tgt + 1, 0, 8'h00);
            check(32'(digital_lock_flag_o), 32'h1);
            pulses(8, 0, uthr);
            pulses(2, 0, uthr + 8'h01);
            check(32'(digital_lock_flag_o), 32'h0);
            pulses(3, 0, 8'h00);
            pulses(2, 0, lthr);
            pulses(150, 1, 8'h00);
        end
        cfg(0, 2'd0, 2'd0);
        pulses(6, 0, 8'h00);
        wr(10'h01d, 8'h08);
        wr(10'h017, 8'h08);
        wr(10'h01b, 8'h03);
        wr(10'h0fc, 8'ha5);
        // selector order keeps a non-qualifying mode right before the final zero
        for (k = 0; k < 5; k++) begin
            r = k == 2 ? 4 : k == 3 ? 3 : k == 4 ? 0 : k + 1;
            wr(10'h01a, r[7:0]);
            check(32'({lock_pin_oe_o, lock_pin_source_o, lock_pin_o & lock_pin_oe_o}),
                (r == 0 || r == 4) ? 32'h7 : 32'h0);
        end
        repeat (1000) @(negedge clk_i);
        check(32'({status_pin_o, reference_monitor_pin_o, clk_out_enable_o}), 32'h1c35a);
        repeat (30) @(negedge clk_i);
        check(32'({status_pin_o, reference_monitor_pin_o, holdover_lock_sense_o, clk_out_enable_o}),
            32'h5ffff);
        wr(10'h01d, 8'h00);
        check(32'({status_pin_o, holdover_lock_sense_o}), 32'h1);
        wr(10'h01d, 8'h08);
        wr(10'h017, 8'h04);
        wr(10'h01b, 8'h01);
        check(32'({status_pin_o, reference_monitor_pin_o, lock_pin_o}), 32'h7);
        pulses(2, 0, 8'hff);
        check(32'({status_pin_o, holdover_lock_sense_o, lock_pin_source_o, clk_out_enable_o}),
            32'h0c35a);
        wr(10'h01a, 8'h01);
        ald_on = 1;
        pulses(2, 0, 8'hff);
        wr(10'h01a, 8'h02);
        pulses(2, 0, 8'hff);
        check(32'(ald_seen), 32'h3);
        test_done;
    end
endmodule
